/* File: core/dual_timer_pkg.sv */
// shared constants for the dual countdown timer block
package dual_timer_pkg;
  localparam int unsigned NUM_MODULES  = 2;
  localparam int unsigned UNITS_PER_MOD = 2;
  localparam int unsigned NUM_UNITS    = 4;
  localparam int unsigned CNT_W        = 32;
  localparam int unsigned ADDR_W       = 8;
  // per unit: a block of four words at 0x10 stride
  localparam logic [7:0] UNIT_STRIDE   = 8'h10;
  localparam logic [7:0] OFS_LOAD      = 8'h00;
  localparam logic [7:0] OFS_VALUE     = 8'h04;
  localparam logic [7:0] OFS_CTRL      = 8'h08;
  localparam logic [7:0] OFS_INTCLR    = 8'h0C;
  // combined interrupt status, one word per module
  localparam logic [7:0] OFS_MIS0      = 8'h40;
  localparam logic [7:0] OFS_MIS1      = 8'h44;
  // control field positions
  localparam int unsigned CTRL_ONESHOT = 0;
  localparam int unsigned CTRL_SIZE32  = 1;
  localparam int unsigned CTRL_PRE_LO  = 2;
  localparam int unsigned CTRL_PERIOD  = 4;
  localparam int unsigned CTRL_INTEN   = 5;
  localparam int unsigned CTRL_ENABLE  = 6;
  localparam int unsigned CTRL_W       = 7;
  localparam logic [6:0]  CTRL_RESET   = 7'h20;
  localparam logic [31:0] LOAD_RESET   = 32'h0000_0000;
  localparam logic [31:0] ONES16       = 32'h0000_FFFF;
  localparam logic [31:0] ONES32       = 32'hFFFF_FFFF;
  // prescale codes
  localparam logic [1:0] PRE_DIV1      = 2'h0;
  localparam logic [1:0] PRE_DIV16     = 2'h1;
  localparam logic [1:0] PRE_DIV256    = 2'h2;
  localparam logic [7:0] PRE16_LAST    = 8'h0F;
  localparam logic [7:0] PRE256_LAST   = 8'hFF;
endpackage : dual_timer_pkg

/* File: core/tick_prescaler.sv */
// prescaler giving a one-cycle tick every 1, 16 or 256 enabled clocks
`timescale 1ns/10ps
`default_nettype none
module tick_prescaler
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       restart,
  input  wire logic [1:0] pre_sel,
  output logic            tick
);
  logic [7:0] div_reg;
  logic [7:0] div_next;
  logic [7:0] last;

  always_comb
  begin
    unique case (pre_sel)
      dual_timer_pkg::PRE_DIV16:  last = dual_timer_pkg::PRE16_LAST;
      dual_timer_pkg::PRE_DIV256: last = dual_timer_pkg::PRE256_LAST;
      default:                    last = 8'h00;
    endcase
    div_next = div_reg;
    tick     = 1'b0;
    if (restart)
    begin
      div_next = 8'h00;
    end
    else if (clk_en)
    begin
      if (div_reg >= last)
      begin
        div_next = 8'h00;
        tick     = 1'b1;
      end
      else
      begin
        div_next = div_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      div_reg <= 8'h00;
    else
      div_reg <= div_next;
  end

  a_tick_needs_en : assert property (@(posedge core_clk) disable iff (!rst_n)
    tick |-> clk_en && !restart)
    else $error("prescaler ticked without clock enable");
endmodule : tick_prescaler
`default_nettype wire

/* File: core/countdown_unit.sv */
// one down counter with width, prescale and repetition modes
`timescale 1ns/10ps
`default_nettype none
module countdown_unit
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic [6:0]  ctrl,
  input  wire logic [31:0] load_val,
  input  wire logic        load_wr,
  input  wire logic        ctrl_wr,
  input  wire logic        int_clr,
  output logic [31:0]      count,
  output logic             int_raw,
  output logic             int_out
);
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic        raw_reg;
  logic        raw_next;
  logic        tick;
  logic        enabled;
  logic        size32;
  logic [31:0] wmask;
  logic [31:0] cur;

  assign enabled = ctrl[dual_timer_pkg::CTRL_ENABLE];
  assign size32  = ctrl[dual_timer_pkg::CTRL_SIZE32];
  assign wmask   = size32 ? dual_timer_pkg::ONES32 : dual_timer_pkg::ONES16;
  assign cur     = cnt_reg & wmask;

  tick_prescaler u_pre
  (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en && enabled),
    .restart  (load_wr || ctrl_wr),
    .pre_sel  (ctrl[dual_timer_pkg::CTRL_PRE_LO +: 2]),
    .tick     (tick)
  );

  always_comb
  begin
    cnt_next = cnt_reg;
    raw_next = raw_reg;
    if (int_clr)
      raw_next = 1'b0;
    if (load_wr)
    begin
      cnt_next = load_val;
    end
    else if (tick)
    begin
      if (cur == 32'h0000_0000)
      begin
        if (ctrl[dual_timer_pkg::CTRL_ONESHOT])
          cnt_next = cnt_reg;
        else if (ctrl[dual_timer_pkg::CTRL_PERIOD])
          cnt_next = load_val;
        else
          cnt_next = wmask;
      end
      else
      begin
        cnt_next = (cur - 32'h0000_0001) | (cnt_reg & ~wmask);
        if (cur == 32'h0000_0001)
          raw_next = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cnt_reg <= dual_timer_pkg::LOAD_RESET;
      raw_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      raw_reg <= raw_next;
    end
  end

  assign count   = cur;
  assign int_raw = raw_reg;
  assign int_out = raw_reg && ctrl[dual_timer_pkg::CTRL_INTEN];

  a_zero_sets_int : assert property (@(posedge core_clk) disable iff (!rst_n)
    tick && !load_wr && cur == 32'h0000_0001 |=> raw_reg)
    else $error("reaching zero did not raise interrupt");
  a_oneshot_holds : assert property (@(posedge core_clk) disable iff (!rst_n)
    ctrl[dual_timer_pkg::CTRL_ONESHOT] && cur == 32'h0000_0000 && !load_wr
    && !ctrl_wr |=> cur == 32'h0000_0000)
    else $error("one-shot counter left zero");
  a_hold_no_en : assert property (@(posedge core_clk) disable iff (!rst_n)
    !clk_en && !load_wr |=> $stable(cnt_reg))
    else $error("counter moved without clock enable");
  a_freerun_wrap : assert property (@(posedge core_clk) disable iff (!rst_n)
    tick && !load_wr && cur == 32'h0000_0000 && !ctrl[dual_timer_pkg::CTRL_ONESHOT]
    && !ctrl[dual_timer_pkg::CTRL_PERIOD] |=> cnt_reg == $past(wmask))
    else $error("free-running wrap wrong");
  a_period_reload : assert property (@(posedge core_clk) disable iff (!rst_n)
    tick && !load_wr && cur == 32'h0000_0000 && !ctrl[dual_timer_pkg::CTRL_ONESHOT]
    && ctrl[dual_timer_pkg::CTRL_PERIOD] |=> cnt_reg == $past(load_val))
    else $error("periodic reload wrong");
  a_decrement : assert property (@(posedge core_clk) disable iff (!rst_n)
    tick && !load_wr && cur != 32'h0000_0000 |=> count == $past(cur) - 32'h0000_0001)
    else $error("decrement wrong");
endmodule : countdown_unit
`default_nettype wire

/* File: core/dual_countdown_timer.sv */
// two dual-timer modules, four countdown units, plain register port
// Functional notes
// - two dual-timer modules, each with two independent counters, four in total.
// - each counter counts down, width selectable 32-bit or 16-bit.
// - a counter raises its interrupt when its count reaches zero.
// - each module has one interrupt output combining both its counters.
// - counters share clock and reset; each advances only with its own enable.
// - software picks one-shot or wrapping repetition per counter.
// - wrapping is either free-running or periodic.
// - a prescaler divides the counting clock by 1, 16 or 256.
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module dual_countdown_timer
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  unit_clk_en,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  output logic [1:0]       timer_irq
);
  localparam int unsigned N = dual_timer_pkg::NUM_UNITS;

  logic [31:0] load_reg  [N];
  logic [31:0] load_next [N];
  logic [6:0]  ctrl_reg  [N];
  logic [6:0]  ctrl_next [N];
  logic [31:0] count     [N];
  logic [N-1:0] raw;
  logic [N-1:0] masked;
  logic [N-1:0] load_wr;
  logic [N-1:0] ctrl_wr;
  logic [N-1:0] clr_wr;
  logic [N-1:0] en_sync1_reg;
  logic [N-1:0] en_sync2_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  // enables may come from other clock gating logic or pins: two-stage sync
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      en_sync1_reg <= '0;
      en_sync2_reg <= '0;
    end
    else
    begin
      en_sync1_reg <= unit_clk_en;
      en_sync2_reg <= en_sync1_reg;
    end
  end

  for (genvar u = 0; u < N; u++)
  begin : g_unit
    localparam logic [7:0] BASE = 8'(u * 16);
    assign load_wr[u] = reg_wr && reg_addr == BASE + dual_timer_pkg::OFS_LOAD;
    assign ctrl_wr[u] = reg_wr && reg_addr == BASE + dual_timer_pkg::OFS_CTRL;
    assign clr_wr[u]  = reg_wr && reg_addr == BASE + dual_timer_pkg::OFS_INTCLR;

    always_comb
    begin
      load_next[u] = load_reg[u];
      ctrl_next[u] = ctrl_reg[u];
      if (load_wr[u])
        load_next[u] = reg_wdata;
      if (ctrl_wr[u])
        ctrl_next[u] = reg_wdata[dual_timer_pkg::CTRL_W-1:0];
    end

    always_ff @(posedge core_clk)
    begin
      if (!rst_n)
      begin
        load_reg[u] <= dual_timer_pkg::LOAD_RESET;
        ctrl_reg[u] <= dual_timer_pkg::CTRL_RESET;
      end
      else
      begin
        load_reg[u] <= load_next[u];
        ctrl_reg[u] <= ctrl_next[u];
      end
    end

    // each unit has its own enable but the shared clock and reset
    countdown_unit u_cnt
    (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .clk_en   (en_sync2_reg[u]),
      .ctrl     (ctrl_reg[u]),
      .load_val (load_wr[u] ? reg_wdata : load_reg[u]),
      .load_wr  (load_wr[u]),
      .ctrl_wr  (ctrl_wr[u]),
      .int_clr  (clr_wr[u]),
      .count    (count[u]),
      .int_raw  (raw[u]),
      .int_out  (masked[u])
    );
  end

  // one combined line per module
  assign timer_irq[0] = masked[0] | masked[1];
  assign timer_irq[1] = masked[2] | masked[3];

  always_comb
  begin
    rdata_next = 32'h0000_0000;
    if (reg_rd)
    begin
      for (int i = 0; i < N; i++)
      begin
        if (reg_addr == 8'(i * 16) + dual_timer_pkg::OFS_LOAD)
          rdata_next = load_reg[i];
        if (reg_addr == 8'(i * 16) + dual_timer_pkg::OFS_VALUE)
          rdata_next = count[i];
        if (reg_addr == 8'(i * 16) + dual_timer_pkg::OFS_CTRL)
          rdata_next = {25'h0, ctrl_reg[i]};
      end
      if (reg_addr == dual_timer_pkg::OFS_MIS0)
        rdata_next = {28'h0, raw[1], raw[0], masked[1], masked[0]};
      if (reg_addr == dual_timer_pkg::OFS_MIS1)
        rdata_next = {28'h0, raw[3], raw[2], masked[3], masked[2]};
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      rdata_reg <= 32'h0000_0000;
    else
      rdata_reg <= rdata_next;
  end

  assign reg_rdata = rdata_reg;

  sequence s_irq_cause(int a, int b);
    masked[a] || masked[b];
  endsequence

  // module 0 judged from the raw flags and enables; module 1 check starts from the gated copies
  a_irq_mod0 : assert property (@(posedge core_clk) disable iff (!rst_n)
    timer_irq[0] == ((raw[0] && ctrl_reg[0][dual_timer_pkg::CTRL_INTEN])
                  || (raw[1] && ctrl_reg[1][dual_timer_pkg::CTRL_INTEN])))
    else $error("module 0 interrupt not combined");
  a_irq_mod1 : assert property (@(posedge core_clk) disable iff (!rst_n)
    s_irq_cause(2, 3) |-> timer_irq[1] && (raw[2] || raw[3]))
    else $error("module 1 interrupt missing");
  a_ctrl_write : assert property (@(posedge core_clk) disable iff (!rst_n)
    ctrl_wr[0] |=> ctrl_reg[0] == $past(reg_wdata[6:0]))
    else $error("control write lost");
endmodule : dual_countdown_timer
`default_nettype wire

/* File: verification/tb.sv */
// self-checking bench for the dual countdown timer block
`timescale 1ns/10ps
`default_nettype none
`define CHK(act, exp) begin check_count++; if ((act) !== (exp)) begin bad_count++; \
  $display("ERROR t=%0t got %h want %h", $time, (act), (exp)); end end
module tb;
  logic        core_clk;
  logic        rst_n;
  logic [3:0]  unit_clk_en;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic [1:0]  timer_irq;
  logic [31:0] rd_val;
  logic [6:0]  wrap_ctrl [3];
  logic [31:0] wrap_exp  [3];
  int          bad_count;
  int          check_count;

  dual_countdown_timer DUT
  (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .unit_clk_en (unit_clk_en),
    .reg_addr    (reg_addr),
    .reg_wdata   (reg_wdata),
    .reg_wr      (reg_wr),
    .reg_rd      (reg_rd),
    .reg_rdata   (reg_rdata),
    .timer_irq   (timer_irq)
  );

  initial core_clk = 1'b0;
  always #12.5 core_clk = ~core_clk;

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask : idle

  // load first, then control: the control write restarts the prescaler last
  task automatic arm(input logic [1:0] u, input logic [31:0] ld, input logic [6:0] c);
    wr({2'h0, u, 4'h0} + dual_timer_pkg::OFS_LOAD, ld);
    wr({2'h0, u, 4'h0} + dual_timer_pkg::OFS_CTRL, {25'h0, c});
  endtask : arm

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
    begin
      $display("verification passed");
    end
    else
    begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  initial
  begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    $display("ERROR t=%0t watchdog expired", $time);
    complete_run();
  end

  initial
  begin
    bad_count   = 0;
    check_count = 0;
    rst_n       = 1'b0;
    unit_clk_en = 4'hD;
    reg_addr    = 8'h00;
    reg_wdata   = 32'h0000_0000;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    wrap_ctrl   = '{7'h48, 7'h4A, 7'h58};
    wrap_exp    = '{dual_timer_pkg::ONES16, dual_timer_pkg::ONES32, 32'h0000_0001};
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    // reset state and an unmapped address
    rd(8'h08);
    `CHK(rd_val, {25'h0, dual_timer_pkg::CTRL_RESET})
    rd(8'h04);
    `CHK(rd_val, 32'h0000_0000)
    rd(8'h50);
    `CHK(rd_val, 32'h0000_0000)
    `CHK(timer_irq, 2'h0)
    $display("test reset done");
    // one-shot, divide by 16, load 3
    arm(2'h0, 32'h0000_0003, 7'h65);
    idle(20);
    rd(8'h04);
    `CHK(rd_val, 32'h0000_0002)
    idle(60);
    rd(8'h04);
    `CHK(rd_val, 32'h0000_0000)
    rd(8'h40);
    `CHK(rd_val, 32'h0000_0005)
    `CHK(timer_irq, 2'h1)
    idle(40);
    rd(8'h04);
    `CHK(rd_val, 32'h0000_0000)
    wr(8'h08, 32'h0000_0000);
    wr(8'h00, 32'h0000_0007);
    rd(8'h04);
    `CHK(rd_val, 32'h0000_0007)
    wr(8'h0C, 32'h0000_0001);
    rd(8'h40);
    `CHK(rd_val, 32'h0000_0000)
    $display("test one-shot done");
    // unit 1 held by its own enable; 16-bit width masks the load
    arm(2'h1, 32'h0001_0005, 7'h61);
    idle(20);
    rd(8'h14);
    `CHK(rd_val, 32'h0000_0005)
    @(posedge core_clk) unit_clk_en <= 4'hF;
    idle(20);
    rd(8'h14);
    `CHK(rd_val, 32'h0000_0000)
    rd(8'h40);
    `CHK(rd_val, 32'h0000_000A)
    // unit 2 with its interrupt masked, then unmasked
    arm(2'h2, 32'h0000_0001, 7'h41);
    idle(20);
    rd(8'h44);
    `CHK(rd_val, 32'h0000_0004)
    `CHK(timer_irq, 2'h1)
    wr(8'h1C, 32'h0000_0001);
    idle(2);
    `CHK(timer_irq, 2'h0)
    wr(8'h28, 32'h0000_0061);
    idle(2);
    `CHK(timer_irq, 2'h2)
    rd(8'h44);
    `CHK(rd_val, 32'h0000_0005)
    wr(8'h2C, 32'h0000_0001);
    $display("test enables done");
    // wrapping modes on unit 3, divide by 256, load 1, read between 2nd and 3rd tick
    for (int i = 0; i < 3; i++)
    begin
      arm(2'h3, 32'h0000_0001, wrap_ctrl[i]);
      idle(640);
      rd(8'h34);
      `CHK(rd_val, wrap_exp[i])
    end
    `CHK(timer_irq, 2'h0)
    $display("test wrapping done");
    complete_run();
  end
endmodule : tb
`default_nettype wire
